// File: verilog/twowire_port_pkg.sv
// Summary of operation
// RULE1 - device holds data low through the ninth clock after each received byte
// RULE2 - master drives data low on ninth clock to accept a read byte
// RULE3 - master leaves last read byte unacknowledged, then sends stop
// RULE4 - write frame: start, address with direction 0, pointer, data bytes, stop
// RULE5 - device acknowledges a matching slave address on the ninth clock
// RULE6 - first byte after write address loads the register pointer, acknowledged
// RULE7 - later write bytes stored at pointer, acknowledged, pointer then advances
// RULE8 - plain start then read address resets pointer to zero, sends register zero
// RULE9 - transmitted data bit is valid at the rising serial clock edge
// RULE10 - pointer advances by one after every transmitted byte
// RULE11 - pointer preset by write then repeated start read returns chosen register
// RULE12 - pointer saturates at top address, reads keep returning top register
// RULE13 - addresses from F6 to FF are reserved locations
// RULE14 - master may stop a read after any byte count, device accepts it
// RULE15 - master treats missing acknowledge as failure and may retry
// RULE16 - slave address chosen by select pin level: low 8A, high 88
// RULE17 - stop detected anywhere except within the start's own clock high period
// RULE18 - data line left released on ack clock when address does not match
package twowire_port_pkg;

    // ********************************
    // addresses and register space
    // ********************************
    localparam logic [6:0] ADDR_PIN_LOW = 7'h45;   // write byte 8A
    localparam logic [6:0] ADDR_PIN_HIGH = 7'h44;  // write byte 88
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] PTR_TOP = 8'hFF;
    localparam logic [7:0] RESERVED_FIRST = 8'hF6;
    localparam logic [7:0] RESERVED_VALUE = 8'h00;
    localparam int REG_COUNT = 256;
    localparam logic [3:0] BIT_ACK = 4'h8;         // bit index of the ninth clock

    // ********************************
    // types
    // ********************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_PTR = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_IGNORE = 3'b101
    } link_state_t;

    // write port toward the register file
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;

    // filtered bus lines and their events
    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } bus_events_t;

endpackage

// File: verilog/line_sync.sv
`timescale 1ns/100ps
// ********************************
// three-stage synchroniser with agreement filter
// ********************************
module line_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout,
    output logic rise,
    output logic fall
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // first stage read only by second; level idles high like the bus
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // the accepted level changes only when stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dout <= 1'b1;
        end else if (s2_q == s3_q) begin
            dout <= s3_q;
        end
    end

    // edges flag in the cycle before the accepted level moves; one cycle sooner
    // keeps the slave's data change ahead of the master's next clock rise
    assign rise = (s2_q == s3_q) && s3_q && !dout;
    assign fall = (s2_q == s3_q) && !s3_q && dout;
endmodule

// File: verilog/sensor_twowire_register_port.sv
`timescale 1ns/100ps
// ********************************
// two-wire slave giving byte access to the internal register file
// ********************************
module sensor_twowire_register_port (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic address_select_pin,
    output twowire_port_pkg::reg_write_t reg_write,
    output logic [7:0] reg_pointer,
    output logic frame_active
);
    import twowire_port_pkg::*;

    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;
    bus_events_t ev;
    link_state_t state_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic [7:0] tx_q;
    logic sel_lvl;
    logic ack_q;
    logic master_nack_q;
    logic start_seen_q;
    logic after_start_plain_q;
    logic [7:0] regs_q [REG_COUNT];
    logic [7:0] rx_byte;
    logic addr_match;
    logic ptr_next_sat;
    logic [6:0] own_addr;

    line_sync u_scl (
        .clk(core_clk),
        .rst_n(rst_n),
        .din(scl_in),
        .dout(scl_lvl),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    line_sync u_sda (
        .clk(core_clk),
        .rst_n(rst_n),
        .din(sda_in),
        .dout(sda_lvl),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    // the select pin is a pin like the others; only its level is used
    line_sync u_sel (
        .clk(core_clk),
        .rst_n(rst_n),
        .din(address_select_pin),
        .dout(sel_lvl),
        .rise(),
        .fall()
    );

    // ********************************
    // bus events
    // ********************************
    // start and stop are data edges with the clock high
    always_comb begin
        ev.scl = scl_lvl;
        ev.sda = sda_lvl;
        ev.scl_rise = scl_rise;
        ev.scl_fall = scl_fall;
        ev.start = sda_fall && scl_lvl;
        ev.stop = sda_rise && scl_lvl && !start_seen_q;  // RULE17
    end

    // remember a start until the clock falls, so a stop in that high phase is ignored
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            start_seen_q <= 1'b0;
        end else if (ev.start) begin
            start_seen_q <= 1'b1;
        end else if (ev.scl_fall) begin
            start_seen_q <= 1'b0;
        end
    end

    // pin level picks the address; the level is read live, no strap latch needed
    assign own_addr = sel_lvl ? ADDR_PIN_HIGH : ADDR_PIN_LOW;  // RULE16
    assign rx_byte = {shift_q[6:0], ev.sda};
    // the full byte is shifted in: address in the top seven bits, direction last
    assign addr_match = (shift_q[7:1] == own_addr);
    assign ptr_next_sat = (ptr_q == PTR_TOP);

    // ********************************
    // frame state machine
    // ********************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            after_start_plain_q <= 1'b0;
            master_nack_q <= 1'b0;
        end else if (ev.start) begin
            state_q <= ST_ADDR;
            bit_q <= 4'h0;
            // a repeated start keeps the pointer; a plain one after idle does not
            after_start_plain_q <= (state_q == ST_IDLE);
        end else if (ev.stop) begin
            state_q <= ST_IDLE;  // RULE14
            bit_q <= 4'h0;
        end else if (ev.scl_rise) begin
            if (bit_q < BIT_ACK) begin
                shift_q <= rx_byte;
            end else if (state_q == ST_RDATA) begin
                master_nack_q <= ev.sda;  // RULE2
            end
        end else if (ev.scl_fall && state_q != ST_IDLE && !start_seen_q) begin
            // the fall that closes a start's high phase is not a bit slot
            if (bit_q == BIT_ACK) begin
                bit_q <= 4'h0;
                case (state_q)
                    ST_ADDR: begin
                        if (!addr_match) begin
                            state_q <= ST_IGNORE;
                        end else if (shift_q[0]) begin
                            state_q <= ST_RDATA;
                        end else begin
                            state_q <= ST_PTR;
                        end
                    end
                    ST_PTR: state_q <= ST_WDATA;
                    // a master nack leaves the line alone until start or stop
                    ST_RDATA: state_q <= master_nack_q ? ST_IGNORE : ST_RDATA;  // RULE3
                    default: state_q <= state_q;
                endcase
            end else begin
                bit_q <= bit_q + 4'h1;
            end
        end
    end

    // acknowledge only for bytes this device takes in
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else if (ev.start || ev.stop) begin
            ack_q <= 1'b0;
        end else if (ev.scl_fall && bit_q == 4'h7) begin
            case (state_q)
                ST_ADDR: ack_q <= addr_match;  // RULE5 RULE18
                ST_PTR: ack_q <= 1'b1;         // RULE6
                ST_WDATA: ack_q <= 1'b1;       // RULE1 RULE7
                default: ack_q <= 1'b0;
            endcase
        end else if (ev.scl_fall && bit_q == BIT_ACK) begin
            ack_q <= 1'b0;  // held through the whole ninth high phase
        end
    end

    // ********************************
    // pointer and register file
    // ********************************
    // next pointer, shared by the pointer register and the transmit reload
    always_comb begin
        ptr_d = ptr_q;
        if (ev.scl_fall && bit_q == BIT_ACK) begin
            case (state_q)
                ST_ADDR: begin
                    if (addr_match && shift_q[0] && after_start_plain_q) begin
                        ptr_d = PTR_RESET;  // RULE8
                    end
                end
                ST_PTR: ptr_d = shift_q;  // RULE6 RULE11
                ST_WDATA, ST_RDATA: begin
                    if (!ptr_next_sat) begin  // RULE12
                        ptr_d = 8'(ptr_q + 8'h01);  // RULE7 RULE10
                    end
                end
                default: ptr_d = ptr_q;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ptr_q <= PTR_RESET;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    // storage; reserved top locations are not writable and read fixed
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else if (ev.scl_fall && bit_q == BIT_ACK && state_q == ST_WDATA) begin
            if (ptr_q < RESERVED_FIRST) begin
                regs_q[ptr_q] <= shift_q;  // RULE7 RULE13
            end
        end
    end

    // exported write strobe, one cycle per received data byte, reserved addresses included
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_write <= '0;
        end else begin
            reg_write.en <= ev.scl_fall && bit_q == BIT_ACK && state_q == ST_WDATA;
            reg_write.addr <= ptr_q;
            reg_write.data <= shift_q;
        end
    end

    // ********************************
    // transmit path
    // ********************************
    // load on the falling edge that starts each byte so bits settle before rise;
    // the next pointer is used so a reset or advance in this same cycle is seen
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_q <= 8'hFF;
        end else if (ev.scl_fall && bit_q == BIT_ACK) begin
            tx_q <= (ptr_d >= RESERVED_FIRST) ? RESERVED_VALUE : regs_q[ptr_d];
        end else if (ev.scl_fall && state_q == ST_RDATA && bit_q < 4'h7) begin
            tx_q <= {tx_q[6:0], 1'b1};  // RULE9
        end
    end

    // open drain: the pin is only ever pulled low, never driven high
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sda_out <= 1'b1;
            sda_oe <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe <= ack_q
                || (state_q == ST_RDATA && bit_q < BIT_ACK && !tx_q[7]);  // RULE9
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_pointer <= PTR_RESET;
            frame_active <= 1'b0;
        end else begin
            reg_pointer <= ptr_q;
            frame_active <= (state_q != ST_IDLE);
        end
    end
endmodule

// File: dv/twowire_master_model.sv
`timescale 1ns/100ps
// ********************************
// bus master; its clock stands high outside frames
// ********************************
module twowire_master_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // idle bus: both lines released to the pull-ups
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one bit: data moves mid-low, sampled at the rising clock edge itself
    task automatic slot(input logic b, output logic s);
        scl = 1'b0;
        #300 sda_low = ~b;
        #300 scl = 1'b1;
        s = sda;
        #200;
    endtask
    // start is held long enough for the slave's input filter; the extra 20 ns
    // keeps every line change off the sampling clock's edges, stop gives it back
    task automatic start();
        #320 sda_low = 1'b1;
        #700;
    endtask
    task automatic rstart();
        scl = 1'b0;
        #300 sda_low = 1'b0;
        #300 scl = 1'b1;
        #200 sda_low = 1'b1;
        #600;
    endtask
    task automatic stop();
        scl = 1'b0;
        #300 sda_low = 1'b1;
        #300 scl = 1'b1;
        #200 sda_low = 1'b0;
        #780;
    endtask
    // ack is reported as 1 when the slave pulled the line low
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) slot(d[i], s);
        slot(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(output logic [7:0] d, input logic more);
        logic s;
        for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
        slot(~more, s);
    endtask
endmodule

// File: dv/sensor_twowire_register_port_chk.sv
`timescale 1ns/100ps
// ********************************
// pin-level checker for the slave
// ********************************
module sensor_twowire_register_port_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic address_select_pin,
    input wire twowire_port_pkg::reg_write_t reg_write,
    input wire logic [7:0] reg_pointer,
    input wire logic frame_active
);
    import twowire_port_pkg::*;
    default clocking dflt @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // the line is only ever pulled low, and held across the clock high
    open_drain_a: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    ack_held_a: assert property (sda_oe && scl_in |=> sda_oe)
        else $error("pull-down dropped while clock high");
    bit_steady_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data moved while clock high");
    idle_quiet_a: assert property (!frame_active |-> !sda_oe)
        else $error("line pulled outside a frame");
    stop_closes_a: assert property (scl_in && $past(scl_in) && $rose(sda_in)
        |-> ##[1:8] !frame_active)
        else $error("stop not seen");
    start_high_a: assert property ($rose(frame_active) |-> scl_in)
        else $error("frame opened without start");
    store_in_frame_a: assert property (reg_write.en |-> frame_active)
        else $error("store outside a frame");
    store_once_a: assert property (reg_write.en |=> !reg_write.en)
        else $error("store strobe too long");
endmodule
bind sensor_twowire_register_port sensor_twowire_register_port_chk u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(address_select_pin),
    .reg_write(reg_write), .reg_pointer(reg_pointer), .frame_active(frame_active));

// File: dv/sensor_twowire_register_port_bench.sv
`timescale 1ns/100ps
module sensor_twowire_register_port_bench;
    import twowire_port_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic address_select_pin = 1'b0;
    logic scl, m_low, sda_out, sda_oe, frame_active, sda, ack;
    reg_write_t reg_write;
    logic [7:0] reg_pointer, d, p;
    logic [7:0] mem [256];
    logic [15:0] wq [$];
    int errors = 0;
    int checks = 0;
    always #50 core_clk = ~core_clk;
    // wired-and with pull-up: a released line reads high
    assign sda = ~(m_low | (sda_oe & ~sda_out));
    twowire_master_model u_mst (.scl(scl), .sda_low(m_low), .sda(sda));
    sensor_twowire_register_port u_dut (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_select_pin(address_select_pin), .reg_write(reg_write),
        .reg_pointer(reg_pointer), .frame_active(frame_active));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask
    task automatic cmp_ack(input logic got, input logic exp);
        cmp({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    function automatic logic [7:0] waddr();
        return {address_select_pin ? ADDR_PIN_HIGH : ADDR_PIN_LOW, 1'b0};
    endfunction
    // every store strobe must carry the next expected address and data
    always @(posedge core_clk) begin
        if (reg_write.en === 1'b1) cmp({reg_write.addr, reg_write.data}, wq.pop_front());
    end
    task automatic wr_frame(input logic [7:0] pa, input int cnt);
        u_mst.start();
        u_mst.wbyte(waddr(), ack);
        cmp_ack(ack, 1'b1);
        u_mst.wbyte(pa, ack);
        cmp_ack(ack, 1'b1);
        p = pa;
        repeat (cnt) begin
            d = 8'($urandom);
            wq.push_back({p, d});
            if (p < RESERVED_FIRST) mem[p] = d;
            u_mst.wbyte(d, ack);
            cmp_ack(ack, 1'b1);
            p++;
        end
        u_mst.stop();
        cmp({8'h00, reg_pointer}, {8'h00, p});
        $display("write frame from %0h done", pa);
    endtask
    // plain read starts at zero; indexed read presets the pointer first
    task automatic rd_frame(input logic [7:0] pa, input int cnt, input logic idx);
        u_mst.start();
        p = PTR_RESET;
        if (idx) begin
            u_mst.wbyte(waddr(), ack);
            u_mst.wbyte(pa, ack);
            u_mst.rstart();
            p = pa;
        end
        u_mst.wbyte(waddr() | 8'h01, ack);
        cmp_ack(ack, 1'b1);
        for (int i = 1; i <= cnt; i++) begin
            u_mst.rbyte(d, i < cnt);
            cmp({8'h00, d}, {8'h00, p >= RESERVED_FIRST ? RESERVED_VALUE : mem[p]});
            if (p != PTR_TOP) p++;
        end
        u_mst.stop();
        $display("read frame to %0h done", p);
    endtask
    initial begin
        foreach (mem[k]) mem[k] = 8'h00;
        checks = $urandom(51);
        checks = 0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        wr_frame(8'h00, 2);
        wr_frame(8'hF4, 3);
        rd_frame(8'h00, 3, 1'b0);
        rd_frame(8'hF3, 2, 1'b1);
        rd_frame(8'hFD, 5, 1'b1);
        // select pin high: the other address is ignored, then retried
        @(posedge core_clk) address_select_pin <= 1'b1;
        u_mst.start();
        u_mst.wbyte({ADDR_PIN_LOW, 1'b0}, ack);
        u_mst.stop();
        cmp_ack(ack, 1'b0);
        wr_frame(8'h10, 1);
        // stop in the middle of the pointer byte
        u_mst.start();
        u_mst.wbyte(waddr(), ack);
        repeat (3) u_mst.slot(1'b0, ack);
        u_mst.stop();
        cmp_ack(frame_active, 1'b0);
        repeat (4) begin
            @(posedge core_clk) address_select_pin <= 1'($urandom_range(1));
            wr_frame(8'($urandom_range(8'hEF)), 1 + $urandom_range(3));
            rd_frame(8'($urandom_range(8'hF0)), 3, 1'b1);
        end
        cmp(16'(wq.size()), 16'h0000);
        results();
    end
    // watchdog well beyond the expected run of about 0.6 ms
    initial begin
        #2000000;
        errors++;
        results();
    end
endmodule
